// File: logic/fspg_pkg.sv
// Constants and types for the flash self-program guard
// Function
// RULE1 - Stores from application region are ignored
// RULE2 - Boot-region stores may target any address
// RULE3 - Busy region programming keeps CPU running
// RULE4 - Stall CPU while programming no-read-while-write region
// RULE5 - Busy flag reads one while region blocked
// RULE6 - Software clears busy before reading region
// RULE7 - Software never reads busy region
// RULE8 - Boot region always inside no-read-while-write region
// RULE9 - Stall depends on target page region
// RULE10 - Boot boundary from fuses, other boundary fixed
// RULE11 - Boot locks set by software, cleared by erase
// RULE12 - General write lock ignores stores
// RULE13 - General read/write lock ignores loads and stores
// RULE14 - Application pair 11: no restriction
// RULE15 - Application pair 10: stores rejected
// RULE16 - Application pair 00: stores and boot loads rejected
// RULE17 - Application pair 01: boot-code loads rejected
// RULE18 - Boot pair 11: no restriction
// RULE19 - Boot pair 10: stores rejected
// RULE20 - Boot pair 00: stores and application loads rejected
// RULE21 - Boot pair 01: application-code loads rejected
// RULE22 - Busy set on start, cleared by reenable/load
// RULE23 - Rejected access changes nothing, no stall
// RULE24 - Stall released in completion cycle
package fspg_pkg;
    localparam int unsigned ADDR_W = 15;
    localparam logic [14:0] NO_READ_WHILE_WRITE_REGION_START = 15'h4c00;
    localparam logic [14:0] BOOT_START_0 = 15'h7e00;
    localparam logic [14:0] BOOT_START_1 = 15'h7c00;
    localparam logic [14:0] BOOT_START_2 = 15'h7800;
    localparam logic [14:0] BOOT_START_3 = 15'h7000;
    localparam logic [1:0] LOCK_INIT = 2'h3;
    localparam logic [1:0] LOCK_NONE = 2'h3;
    localparam logic [1:0] LOCK_NOWR = 2'h2;
    localparam logic [1:0] LOCK_ALL = 2'h0;
    localparam logic [1:0] LOCK_NORD = 2'h1;
    // Register map on the plain port
    localparam logic [1:0] REG_STATUS = 2'h0;
    localparam logic [1:0] REG_LOCKS = 2'h1;
    localparam logic [1:0] REG_CTRL = 2'h2;
    localparam int unsigned BIT_BUSY = 0;
    localparam int unsigned BIT_STALL = 1;
    localparam int unsigned BIT_REENABLE = 0;
    localparam int unsigned BIT_CHIP_ERASE = 1;
    typedef enum logic [1:0] {
        FSPG_IDLE = 2'b00,
        FSPG_RWW = 2'b01,
        FSPG_NO_READ_WHILE_WRITE_REGION = 2'b10
    } fspg_state_type;
endpackage

// File: logic/fspg_guard.sv
// Access guard and region sequencing for flash self-programming
//
// The strobed register port and the register offsets were left to the implementer.
module fspg_guard
    import fspg_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [1:0] boot_size_fuses, // Boot region size select
    input wire logic [14:0] pc_addr, // Address of executing instruction
    input wire logic store_req, // Program-memory store issued
    input wire logic store_erase, // Store is a page erase
    input wire logic store_write, // Store is a page write
    input wire logic store_lock, // Store sets boot lock bits
    input wire logic [3:0] store_lock_data, // New lock bits, zeros program
    input wire logic [14:0] store_addr, // Store target address
    input wire logic load_req, // Program-memory load issued
    input wire logic [14:0] load_addr, // Load target address
    input wire logic flash_done, // Flash finished erase or write
    input wire logic [1:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [7:0] reg_rdata, // Register read data
    output logic store_grant, // Store passed to flash
    output logic load_grant, // Load allowed
    output logic page_load, // Store fills page buffer
    output logic cpu_stall, // Halt the CPU
    output logic region_busy_flag, // Read-while-write region blocked
    output logic irq_block // Mask interrupts in current region
);
    fspg_state_type state;
    fspg_state_type next_state;
    logic [1:0] application_lock_pair;
    logic [1:0] boot_region_lock_pair;
    logic next_busy;

    ////////////////////////////////////////////////////////////////////////////
    // Region decoding
    logic [14:0] boot_start;
    // RULE10
    assign boot_start = boot_size_fuses == 2'h3 ? BOOT_START_0 :
                        boot_size_fuses == 2'h2 ? BOOT_START_1 :
                        boot_size_fuses == 2'h1 ? BOOT_START_2 : BOOT_START_3;

    function automatic logic in_boot(input logic [14:0] a, input logic [14:0] b);
        return a >= b;
    endfunction

    function automatic logic in_no_read_while_write_region(input logic [14:0] a);
        return a >= NO_READ_WHILE_WRITE_REGION_START; // RULE10 RULE8
    endfunction

    wire pc_boot = in_boot(pc_addr, boot_start);
    wire st_boot = in_boot(store_addr, boot_start);
    wire ld_boot = in_boot(load_addr, boot_start);

    ////////////////////////////////////////////////////////////////////////////
    // Lock checks; general lock modes do not enter here
    wire app_wr_lock = application_lock_pair == LOCK_NOWR ||
                       application_lock_pair == LOCK_ALL; // RULE15 RULE16 RULE14
    wire app_rd_lock = application_lock_pair == LOCK_ALL ||
                       application_lock_pair == LOCK_NORD; // RULE16 RULE17
    wire boot_wr_lock = boot_region_lock_pair == LOCK_NOWR ||
                        boot_region_lock_pair == LOCK_ALL; // RULE19 RULE20 RULE18
    wire boot_rd_lock = boot_region_lock_pair == LOCK_ALL ||
                        boot_region_lock_pair == LOCK_NORD; // RULE20 RULE21

    // RULE1 RULE2 RULE12 RULE13
    wire wr_locked = st_boot ? boot_wr_lock : app_wr_lock;
    wire store_ok = store_req && pc_boot && state == FSPG_IDLE &&
                    (store_lock || !((store_erase || store_write) && wr_locked));
    wire prog_start = store_ok && (store_erase || store_write);
    wire target_no_read_while_write_region = in_no_read_while_write_region(store_addr); // RULE9

    // Loads across regions are governed by the pair of the target; busy also blocks loads below the no-read-while-write region
    wire ld_cross = pc_boot != ld_boot;
    wire ld_locked = ld_cross && (ld_boot ? boot_rd_lock : app_rd_lock);
    wire ld_busy = region_busy_flag && !in_no_read_while_write_region(load_addr); // RULE7
    assign load_grant = load_req && !ld_locked && !ld_busy; // RULE23
    assign store_grant = store_ok; // RULE23
    assign page_load = store_ok && !store_erase && !store_write && !store_lock;

    // RULE16 RULE17 RULE20 RULE21
    assign irq_block = pc_boot ? boot_rd_lock : app_rd_lock;

    ////////////////////////////////////////////////////////////////////////////
    // Programming sequence
    always_comb begin
        next_state = state;
        case (state)
            FSPG_IDLE: begin
                if (prog_start) begin
                    next_state = target_no_read_while_write_region ? FSPG_NO_READ_WHILE_WRITE_REGION : FSPG_RWW; // RULE3 RULE4
                end
            end
            FSPG_RWW, FSPG_NO_READ_WHILE_WRITE_REGION: begin
                if (flash_done) begin
                    next_state = FSPG_IDLE;
                end
            end
            default: next_state = FSPG_IDLE;
        endcase
    end

    // RULE4 RULE24 RULE3
    assign cpu_stall = state == FSPG_NO_READ_WHILE_WRITE_REGION && !flash_done;

    wire reenable = reg_wr && reg_addr == REG_CTRL && reg_wdata[BIT_REENABLE];
    wire chip_erase = reg_wr && reg_addr == REG_CTRL && reg_wdata[BIT_CHIP_ERASE];

    // RULE22 RULE6
    assign next_busy = (prog_start && !target_no_read_while_write_region) ? 1'b1 :
                       ((reenable && state == FSPG_IDLE) || page_load) ? 1'b0 :
                       region_busy_flag;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= FSPG_IDLE;
            region_busy_flag <= 1'b0;
        end else begin
            state <= next_state;
            region_busy_flag <= next_busy; // RULE5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Boot lock bits: only programmed by stores, cleared by chip erase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            application_lock_pair <= LOCK_INIT;
            boot_region_lock_pair <= LOCK_INIT;
        end else if (chip_erase) begin
            application_lock_pair <= LOCK_INIT; // RULE11
            boot_region_lock_pair <= LOCK_INIT;
        end else if (store_ok && store_lock) begin
            application_lock_pair <= application_lock_pair & store_lock_data[1:0]; // RULE11
            boot_region_lock_pair <= boot_region_lock_pair & store_lock_data[3:2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port
    wire [7:0] rd_mux = reg_addr == REG_STATUS ?
                        {6'h00, state == FSPG_NO_READ_WHILE_WRITE_REGION, region_busy_flag} :
                        reg_addr == REG_LOCKS ?
                        {4'h0, boot_region_lock_pair, application_lock_pair} : 8'h00;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    app_store_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        store_req && !pc_boot |-> !store_grant) else $error("app store granted"); // RULE1
    stall_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        prog_start && target_no_read_while_write_region |=> cpu_stall) else $error("no stall"); // RULE4
    no_stall_rww_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state == FSPG_RWW |-> !cpu_stall) else $error("stall in rww"); // RULE3
    busy_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        prog_start && !target_no_read_while_write_region |=> region_busy_flag) else $error("busy not set"); // RULE22
    busy_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reg_rd && reg_addr == REG_STATUS |=> reg_rdata[BIT_BUSY] == $past(region_busy_flag))
        else $error("busy read wrong"); // RULE5
    stall_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        flash_done |-> !cpu_stall) else $error("stall held"); // RULE24
    app_wr_lock_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        store_write && !st_boot && application_lock_pair[0] == 1'b0 |-> !store_grant)
        else $error("app write lock"); // RULE15
    boot_rd_lock_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        load_req && ld_boot && !pc_boot && !boot_region_lock_pair[1] |-> !load_grant)
        else $error("boot read lock"); // RULE21
    lock_erase_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        chip_erase |=> application_lock_pair == LOCK_INIT) else $error("erase locks"); // RULE11
    rww_prog_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
        prog_start && !target_no_read_while_write_region ##[1:20] flash_done);
    no_read_while_write_region_prog_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
        prog_start && target_no_read_while_write_region ##[1:20] flash_done);
    reenable_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
        region_busy_flag ##1 !region_busy_flag);
endmodule

// File: testbench/fspg_flash_model.sv
// Flash array stand-in that finishes each erase or write after a fixed delay
module fspg_flash_model #(
    parameter int DONE_LAT = 12 // Cycles from start to completion
) (
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Reset, active low
    input wire logic start, // Granted erase or write
    output logic flash_done // Completion pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt == 1);
            if (start) begin
                cnt <= DONE_LAT;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// File: testbench/fspg_guard_test.sv
// Self-checking bench for the flash self-program guard
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module fspg_guard_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fspg_pkg::*;
    localparam logic [14:0] PCB = 15'h7f00;
    localparam logic [14:0] PCA = 15'h0200;
    logic sys_clk, arst_n = 0, store_req = 0, store_erase = 0, store_write = 0, store_lock = 0;
    logic load_req = 0, reg_wr = 0, reg_rd = 0, flash_done, store_grant, load_grant, page_load;
    logic cpu_stall, region_busy_flag, irq_block, g;
    logic [1:0] boot_size_fuses = 2'h3, reg_addr = 2'h0;
    logic [3:0] store_lock_data = 4'h0, d;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rd;
    logic [14:0] pc_addr = PCB, store_addr = 15'h0000, load_addr = 15'h0000, aa, ba;
    logic [14:0] bstart [4] = '{BOOT_START_3, BOOT_START_2, BOOT_START_1, BOOT_START_0};
    logic [31:0] rnd = 32'hb247;
    int num_errors = 0, compares = 0;
    fspg_guard u_fspg_guard (.sys_clk(sys_clk), .arst_n(arst_n), .boot_size_fuses(boot_size_fuses),
        .pc_addr(pc_addr), .store_req(store_req), .store_erase(store_erase),
        .store_write(store_write), .store_lock(store_lock), .store_lock_data(store_lock_data),
        .store_addr(store_addr), .load_req(load_req), .load_addr(load_addr),
        .flash_done(flash_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_grant(store_grant),
        .load_grant(load_grant), .page_load(page_load), .cpu_stall(cpu_stall),
        .region_busy_flag(region_busy_flag), .irq_block(irq_block));
    fspg_flash_model u_fspg_flash_model (.sys_clk(sys_clk), .arst_n(arst_n),
        .start(store_grant & (store_erase | store_write)), .flash_done(flash_done));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Stores pass unless the lower bit of the pair is programmed (pairs 10 and 00)
    function automatic logic exp_st(input logic [1:0] p);
        return p == LOCK_NONE || p == LOCK_NORD;
    endfunction
    task automatic idle();
        @(posedge sys_clk);
        store_req <= 1'b0;
        load_req <= 1'b0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic store(input logic [14:0] pc, input logic [2:0] k, input logic [14:0] a);
        @(posedge sys_clk);
        pc_addr <= pc;
        store_req <= 1'b1;
        {store_erase, store_write, store_lock} <= k;
        store_addr <= a;
        store_lock_data <= d;
        #1;
    endtask
    task automatic load(input logic [14:0] pc, input logic [14:0] a);
        @(posedge sys_clk);
        pc_addr <= pc;
        load_req <= 1'b1;
        load_addr <= a;
        #1;
    endtask
    task automatic reg_access(input logic w, input logic [1:0] a, input logic [7:0] wd);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= wd;
        idle();
        rd = reg_rdata;
    endtask
    task automatic wait_done(input logic st, input logic bz);
        for (int i = 0; i < 100; i++) begin
            @(posedge sys_clk);
            #1;
            if (flash_done === 1'b1) begin
                `CHK("stall_at_done", 1'b0, cpu_stall)
                return;
            end
            `CHK("stall", st, cpu_stall)
            `CHK("busy", bz, region_busy_flag)
        end
        num_errors++;
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        d = 4'h0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        reg_access(1'b0, REG_LOCKS, 8'h00);
        `CHK("locks_reset", 8'h0f, rd)
        for (int f = 0; f < 4; f++) begin
            @(posedge sys_clk);
            boot_size_fuses <= f[1:0];
            store(bstart[f] - 15'h0001, 3'b000, 15'h0100);
            `CHK("app_store", 1'b0, page_load)
            store(bstart[f], 3'b000, 15'h0100);
            `CHK("boot_store", 1'b1, page_load)
            idle();
        end
        store(PCB, 3'b010, 15'h0100);
        `CHK("rww_grant", 1'b1, store_grant)
        idle();
        `CHK("rww_busy", 1'b1, region_busy_flag)
        load(PCB, 15'h0040);
        `CHK("busy_load", 1'b0, load_grant)
        load(PCB, 15'h7f10);
        `CHK("no_read_while_write_region_load", 1'b1, load_grant)
        reg_access(1'b1, REG_CTRL, 8'h01);
        `CHK("early_reenable", 1'b1, region_busy_flag)
        wait_done(1'b0, 1'b1);
        reg_access(1'b1, REG_CTRL, 8'h01);
        `CHK("reenable", 1'b0, region_busy_flag)
        load(PCB, 15'h0040);
        `CHK("rww_load", 1'b1, load_grant)
        store(PCB, 3'b100, 15'h0800);
        idle();
        wait_done(1'b0, 1'b1);
        store(PCB, 3'b000, 15'h0800);
        idle();
        `CHK("load_clears", 1'b0, region_busy_flag)
        store(PCB, 3'b010, 15'h7e40);
        idle();
        `CHK("no_read_while_write_region_busy", 1'b0, region_busy_flag)
        wait_done(1'b1, 1'b0);
        for (int m = 0; m < 16; m++) begin
            d = m[3:0];
            rnd = lfsr(rnd);
            aa = {2'b00, rnd[12:0]};
            ba = 15'h7e00 | {6'h00, rnd[24:16]};
            reg_access(1'b1, REG_CTRL, 8'h02);
            store(PCB, 3'b001, 15'h0000);
            idle();
            reg_access(1'b0, REG_LOCKS, 8'h00);
            `CHK("locks", {4'h0, d}, rd)
            load(PCB, aa);
            `CHK("app_load", d[1], load_grant)
            load(PCA, ba);
            `CHK("boot_load", d[3], load_grant)
            `CHK("irq_block", !d[1], irq_block)
            store(PCB, 3'b100, aa);
            `CHK("app_erase", exp_st(d[1:0]), store_grant)
            g = store_grant;
            idle();
            if (g) begin
                wait_done(1'b0, 1'b1);
                reg_access(1'b1, REG_CTRL, 8'h01);
            end
            store(PCB, 3'b100, ba);
            `CHK("boot_erase", exp_st(d[3:2]), store_grant)
            g = store_grant;
            idle();
            `CHK("stall_start", g, cpu_stall)
            if (g) begin
                wait_done(1'b1, 1'b0);
            end
        end
        print_verdict();
    end
endmodule
